// ### design/bwd_pkg.sv
// package of constants for the board watchdog timer
package bwd_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_FREQ_HZ = 200_000_000;
  localparam int unsigned TICK_MS     = 200;
  localparam int unsigned TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_W      = 26;
  // ****************************************
  // field widths and limits
  // ****************************************
  localparam int unsigned TIMEOUT_W   = 16;
  localparam int unsigned DELAY_W     = 15;
  localparam logic [15:0] TIMEOUT_MAX = 16'hffff;
  localparam logic [14:0] DELAY_MAX   = 15'h7fff;
  // ****************************************
  // action encodings
  // ****************************************
  localparam logic ACTION_RESET = 1'h0;
  localparam logic ACTION_NMI   = 1'h1;
  // ****************************************
  // i2c-side register offsets
  // ****************************************
  localparam logic [7:0] OFS_TIMEOUT_LO = 8'h00;
  localparam logic [7:0] OFS_TIMEOUT_HI = 8'h01;
  localparam logic [7:0] OFS_DELAY_LO   = 8'h02;
  localparam logic [7:0] OFS_DELAY_HI   = 8'h03;
  localparam logic [7:0] OFS_ACTION     = 8'h04;
  localparam logic [7:0] OFS_COMMAND    = 8'h05;
  localparam logic [7:0] OFS_STATUS     = 8'h06;
  localparam logic [7:0] CMD_INIT       = 8'h01;
  localparam logic [7:0] CMD_TRIGGER    = 8'h02;
  // ****************************************
  // states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_ARMED = 2'b11,
    ST_FIRED = 2'b10
  } bwd_state_t;
endpackage : bwd_pkg

// ### design/bwd_i2c_regs.sv
// byte-wide register window fed by a generic i2c transaction engine
`timescale 1ns/10ps
`default_nettype none
module bwd_i2c_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // byte access from i2c engine
  input  wire logic        i2cWrStb,
  input  wire logic        i2cRdStb,
  input  wire logic [7:0]  i2cAddr,
  input  wire logic [7:0]  i2cWrData,
  output logic      [7:0]  i2cRdData,
  // status to read back
  input  wire logic [1:0]  wdState,
  input  wire logic        wdFired,
  // staged settings and commands
  output logic      [15:0] stTimeout,
  output logic      [14:0] stDelay,
  output logic             stAction,
  output logic             i2cInit,
  output logic             i2cTrigger
);
  logic [15:0] timeout_reg;
  logic [14:0] delay_reg;
  logic        action_reg;
  logic [7:0]  rdData_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timeout_reg <= 16'h0000;
      delay_reg   <= 15'h0000;
      action_reg  <= 1'h0;
    end else if (i2cWrStb) begin
      unique case (i2cAddr)
        bwd_pkg::OFS_TIMEOUT_LO: timeout_reg[7:0]  <= i2cWrData;
        bwd_pkg::OFS_TIMEOUT_HI: timeout_reg[15:8] <= i2cWrData;
        bwd_pkg::OFS_DELAY_LO:   delay_reg[7:0]    <= i2cWrData;
        bwd_pkg::OFS_DELAY_HI:   delay_reg[14:8]   <= i2cWrData[6:0];
        bwd_pkg::OFS_ACTION:     action_reg        <= i2cWrData[0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      i2cInit    <= 1'h0;
      i2cTrigger <= 1'h0;
    end else begin
      i2cInit    <= i2cWrStb && i2cAddr == bwd_pkg::OFS_COMMAND
                    && i2cWrData == bwd_pkg::CMD_INIT;
      i2cTrigger <= i2cWrStb && i2cAddr == bwd_pkg::OFS_COMMAND
                    && i2cWrData == bwd_pkg::CMD_TRIGGER;
    end
  end

  // unmapped offsets read as zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdData_reg <= 8'h00;
    end else if (i2cRdStb) begin
      unique case (i2cAddr)
        bwd_pkg::OFS_TIMEOUT_LO: rdData_reg <= timeout_reg[7:0];
        bwd_pkg::OFS_TIMEOUT_HI: rdData_reg <= timeout_reg[15:8];
        bwd_pkg::OFS_DELAY_LO:   rdData_reg <= delay_reg[7:0];
        bwd_pkg::OFS_DELAY_HI:   rdData_reg <= {1'h0, delay_reg[14:8]};
        bwd_pkg::OFS_ACTION:     rdData_reg <= {7'h00, action_reg};
        bwd_pkg::OFS_STATUS:     rdData_reg <= {5'h00, wdFired, wdState};
        default:                 rdData_reg <= 8'h00;
      endcase
    end
  end

  assign stTimeout = timeout_reg;
  assign stDelay   = delay_reg;
  assign stAction  = action_reg;
  assign i2cRdData = rdData_reg;
endmodule : bwd_i2c_regs
`default_nettype wire

// ### design/bwd_watchdog.sv
// board watchdog timer core with firmware-call and i2c control paths
// Summary of operation
// - stay idle until start-up delay elapses
// - expiry gives reset (0) or NMI (1)
// - delay and timeout count 0.2 s units
// - 16-bit timeout; zero switches watchdog off
// - 15-bit delay; zero arms at once
// - control by calls and by i2c
`timescale 1ns/10ps
`default_nettype none
module bwd_watchdog #(
  // prescale cycles per 0.2 s unit; only a testbench shortens it
  parameter int unsigned TICK_CYC = bwd_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // firmware call port
  input  wire logic        initStb,
  input  wire logic [15:0] initTimeout,
  input  wire logic [15:0] initDelay,
  input  wire logic        initAction,
  input  wire logic        triggerStb,
  // i2c byte port
  input  wire logic        i2cWrStb,
  input  wire logic        i2cRdStb,
  input  wire logic [7:0]  i2cAddr,
  input  wire logic [7:0]  i2cWrData,
  output logic      [7:0]  i2cRdData,
  // outputs
  output logic             sysResetOut,
  output logic             nmiOut,
  output logic             armed,
  output logic             initDone
);
  // ****************************************
  // i2c register window
  // ****************************************
  logic [15:0] stTimeout;
  logic [14:0] stDelay;
  logic        stAction;
  logic        i2cInit;
  logic        i2cTrigger;
  bwd_pkg::bwd_state_t state_reg;
  logic        fired_reg;

  // staged bytes and command pulses land one cycle behind the call port
  bwd_i2c_regs uRegs (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .i2cWrStb   (i2cWrStb),
    .i2cRdStb   (i2cRdStb),
    .i2cAddr    (i2cAddr),
    .i2cWrData  (i2cWrData),
    .i2cRdData  (i2cRdData),
    .wdState    (state_reg),
    .wdFired    (fired_reg),
    .stTimeout  (stTimeout),
    .stDelay    (stDelay),
    .stAction   (stAction),
    .i2cInit    (i2cInit),
    .i2cTrigger (i2cTrigger)
  );

  // ****************************************
  // merge the two control paths
  // ****************************************
  logic        doInit;
  logic        doTrig;
  logic [15:0] selTimeout;
  logic [14:0] selDelay;
  logic        selAction;
  logic        firstInit;
  logic        armTrig;

  // call port wins if both init in the same cycle
  assign doInit     = initStb | i2cInit;
  assign doTrig     = triggerStb | i2cTrigger;
  assign selTimeout = initStb ? initTimeout : stTimeout;
  assign selDelay   = initStb ? initDelay[14:0] : stDelay;
  assign selAction  = initStb ? initAction : stAction;

  // triggers outside supervision must not stretch the start-up delay
  assign armTrig    = doTrig && (state_reg == bwd_pkg::ST_ARMED);

  // ****************************************
  // 0.2 s tick prescaler
  // ****************************************
  localparam logic [25:0] TICK_LAST = 26'(TICK_CYC - 1);
  logic [25:0] pre_reg;
  logic        tick;

  assign tick = (pre_reg == TICK_LAST);

  // restarted by init and trigger so each unit is a full 0.2 s
  always_ff @(posedge clk) begin
    if (sys_rst || firstInit || armTrig || tick) begin
      pre_reg <= 26'h0000000;
    end else begin
      pre_reg <= pre_reg + 26'h0000001;
    end
  end

  // ****************************************
  // settings, latched once
  // ****************************************
  logic [15:0] timeout_reg;
  logic        action_reg;
  logic        init_reg;

  // repeated inits are dropped and must leave the timers alone
  assign firstInit = doInit && !init_reg;

  // later inits are ignored; only a reset reopens the settings
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timeout_reg <= 16'h0000;
      action_reg  <= bwd_pkg::ACTION_RESET;
      init_reg    <= 1'h0;
    end else if (firstInit) begin
      timeout_reg <= selTimeout;
      action_reg  <= selAction;
      init_reg    <= 1'h1;
    end
  end

  // ****************************************
  // state machine and counter
  // ****************************************
  // cnt_reg holds delay units first, then timeout units
  logic [15:0] cnt_reg;
  logic        expire;

  // a trigger in the expiry cycle wins
  assign expire = (state_reg == bwd_pkg::ST_ARMED) && !doTrig && tick
                  && (cnt_reg == 16'h0001);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= bwd_pkg::ST_IDLE;
      cnt_reg   <= 16'h0000;
    end else begin
      unique case (state_reg)
        bwd_pkg::ST_IDLE: begin
          if (firstInit) begin
            // zero timeout: settings kept, supervision never starts
            if (selTimeout == 16'h0000) begin
              state_reg <= bwd_pkg::ST_IDLE;
            end else if (selDelay == 15'h0000) begin
              state_reg <= bwd_pkg::ST_ARMED;
              cnt_reg   <= selTimeout;
            end else begin
              state_reg <= bwd_pkg::ST_DELAY;
              cnt_reg   <= {1'h0, selDelay};
            end
          end
        end
        bwd_pkg::ST_DELAY: begin
          // missing triggers do not matter here
          if (tick) begin
            if (cnt_reg == 16'h0001) begin
              state_reg <= bwd_pkg::ST_ARMED;
              cnt_reg   <= timeout_reg;
            end else begin
              cnt_reg <= cnt_reg - 16'h0001;
            end
          end
        end
        bwd_pkg::ST_ARMED: begin
          // reload also restarts the prescaler, so the first unit is whole
          if (doTrig) begin
            cnt_reg <= timeout_reg;
          end else if (tick) begin
            if (cnt_reg == 16'h0001) begin
              state_reg <= bwd_pkg::ST_FIRED;
            end else begin
              cnt_reg <= cnt_reg - 16'h0001;
            end
          end
        end
        bwd_pkg::ST_FIRED: begin
          // no trigger cancels an alarm; only sys_rst leaves
          state_reg <= bwd_pkg::ST_FIRED;
        end
      endcase
    end
  end

  // ****************************************
  // timeout action outputs
  // ****************************************
  // both held until sys_rst; the board reset is expected to clear us
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sysResetOut <= 1'h0;
      nmiOut      <= 1'h0;
      fired_reg   <= 1'h0;
    end else if (expire) begin
      sysResetOut <= (action_reg == bwd_pkg::ACTION_RESET);
      nmiOut      <= (action_reg == bwd_pkg::ACTION_NMI);
      fired_reg   <= 1'h1;
    end
  end

  // ****************************************
  // supervision status
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      armed <= 1'h0;
    end else begin
      armed <= (state_reg == bwd_pkg::ST_ARMED);
    end
  end

  assign initDone = init_reg;
endmodule : bwd_watchdog
`default_nettype wire

// ### test/bwd_host_model.sv
// host firmware model issuing init and trigger calls
`timescale 1ns/10ps
`default_nettype none
module bwd_host_model (
  // clock
  input  wire logic        clk,
  // call port
  output logic             initStb,
  output logic      [15:0] initTimeout,
  output logic      [15:0] initDelay,
  output logic             initAction,
  output logic             triggerStb
);
  initial begin
    {initStb, initTimeout, initDelay, initAction, triggerStb} = '0;
  end
  // all three settings travel in one call
  task automatic doInit(input logic [15:0] t, input logic [15:0] d, input logic a);
    @(negedge clk);
    {initTimeout, initDelay, initAction, initStb} = {t, d, a, 1'h1};
    @(negedge clk);
    initStb = 1'h0;
    // released operands show garbage, not the last value
    {initTimeout, initDelay, initAction} = ~{t, d, a};
  endtask : doInit
  task automatic doTrigger(input int n);
    @(negedge clk);
    triggerStb = 1'h1;
    repeat (n) @(negedge clk);
    triggerStb = 1'h0;
  endtask : doTrigger
endmodule : bwd_host_model
`default_nettype wire

// ### test/bwd_watchdog_checker.sv
// concurrent checks on the watchdog ports
`timescale 1ns/10ps
`default_nettype none
module bwd_watchdog_checker (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // inputs
  input  wire logic        initStb,
  input  wire logic [15:0] initTimeout,
  input  wire logic [15:0] initDelay,
  input  wire logic        i2cRdStb,
  input  wire logic [7:0]  i2cAddr,
  // outputs
  input  wire logic [7:0]  i2cRdData,
  input  wire logic        sysResetOut,
  input  wire logic        nmiOut,
  input  wire logic        armed,
  input  wire logic        initDone
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic first;
  logic goT;
  assign first = initStb && !initDone;
  assign goT   = initTimeout != 16'h0;
  property p_armNow; first && goT && initDelay[14:0] == 15'h0 |=> initDone ##1 armed; endproperty
  a_armNow: assert property (p_armNow) else $error("no prompt arm");
  property p_off; first && !goT |=> (initDone && !armed)[*8]; endproperty
  a_off: assert property (p_off) else $error("zero timeout armed");
  property p_wait; first && goT && initDelay[14:0] != 15'h0 |=> !armed[*8]; endproperty
  a_wait: assert property (p_wait) else $error("armed during delay");
  property p_initHeld; initDone |=> initDone; endproperty
  a_initHeld: assert property (p_initHeld) else $error("init lost");
  property p_armInit; armed |-> initDone; endproperty
  a_armInit: assert property (p_armInit) else $error("armed uninit");
  property p_oneAlarm; !(sysResetOut && nmiOut); endproperty
  a_oneAlarm: assert property (p_oneAlarm) else $error("both alarms");
  property p_alarmHeld; sysResetOut || nmiOut |=> $stable({sysResetOut, nmiOut}); endproperty
  a_alarmHeld: assert property (p_alarmHeld) else $error("alarm dropped");
  property p_alarmArmed; $rose(sysResetOut || nmiOut) |-> armed; endproperty
  a_alarmArmed: assert property (p_alarmArmed) else $error("alarm while unarmed");
  property p_unmapped; i2cRdStb && i2cAddr > 8'h06 |=> i2cRdData == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule : bwd_watchdog_checker
bind bwd_watchdog bwd_watchdog_checker bwd_watchdog_checker_i (.clk(clk), .sys_rst(sys_rst),
  .initStb(initStb), .initTimeout(initTimeout), .initDelay(initDelay), .i2cRdStb(i2cRdStb),
  .i2cAddr(i2cAddr), .i2cRdData(i2cRdData), .sysResetOut(sysResetOut), .nmiOut(nmiOut),
  .armed(armed), .initDone(initDone));
`default_nettype wire

// ### test/tb.sv
// self-checking bench for the board watchdog timer
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk, sys_rst, initStb, initAction, triggerStb, i2cWrStb, i2cRdStb;
  logic [15:0] initTimeout, initDelay;
  logic [7:0]  i2cAddr, i2cWrData, i2cRdData;
  logic        sysResetOut, nmiOut, armed, initDone;
  int          nFail = 0, checks = 0, cyc = 0;
  // short prescale so expiry fits the run; the checker's delay window wants it above 6
  localparam int UNIT = 20;
  bwd_watchdog #(.TICK_CYC(UNIT)) bwd_watchdog_i (.clk(clk), .sys_rst(sys_rst),
    .initStb(initStb),
    .initTimeout(initTimeout), .initDelay(initDelay), .initAction(initAction),
    .triggerStb(triggerStb), .i2cWrStb(i2cWrStb), .i2cRdStb(i2cRdStb), .i2cAddr(i2cAddr),
    .i2cWrData(i2cWrData), .i2cRdData(i2cRdData), .sysResetOut(sysResetOut),
    .nmiOut(nmiOut), .armed(armed), .initDone(initDone));
  bwd_host_model bwd_host_model_i (.clk(clk), .initStb(initStb), .initTimeout(initTimeout),
    .initDelay(initDelay), .initAction(initAction), .triggerStb(triggerStb));
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, nFail);
    if (nFail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  // scenarios need about 320 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      nFail++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      nFail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic outs(input logic [3:0] e);
    chk("initDone armed rst nmi", {4'h0, e}, {4'h0, initDone, armed, sysResetOut, nmiOut});
  endtask : outs
  task automatic doReset();
    // callers stand on a falling edge, or at time zero
    sys_rst = 1'h1;
    repeat (6) @(negedge clk);
    sys_rst = 1'h0;
  endtask : doReset
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {i2cAddr, i2cWrData, i2cWrStb} = {a, d, 1'h1};
    @(negedge clk);
    i2cWrStb = 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    {i2cAddr, i2cRdStb} = {a, 1'h1};
    @(negedge clk);
    i2cRdStb = 1'h0;
    @(negedge clk);
    chk("i2cRdData", e, i2cRdData);
  endtask : rd
  task automatic t_armNow();
    doReset();
    outs(4'h0);
    bwd_host_model_i.doInit(16'h0005, 16'h0000, 1'h0);
    @(negedge clk);
    outs(4'hc);
    bwd_host_model_i.doTrigger(4);
    outs(4'hc);
    bwd_host_model_i.doInit(16'h0000, 16'h0000, 1'h1);
    repeat (4) @(negedge clk);
    outs(4'hc);
    rd(bwd_pkg::OFS_STATUS, 8'h03);
    rd(8'h07, 8'h00);
    // last trigger two edges before the ignored init; expiry five units later
    repeat (5 * UNIT - 13) @(negedge clk);
    outs(4'hc);
    @(negedge clk);
    outs(4'he);
    @(negedge clk);
    outs(4'ha);
    rd(bwd_pkg::OFS_STATUS, 8'h06);
  endtask : t_armNow
  task automatic t_off();
    doReset();
    bwd_host_model_i.doInit(16'h0000, 16'h0000, 1'h0);
    bwd_host_model_i.doTrigger(1);
    repeat (20) @(negedge clk);
    outs(4'h8);
    rd(bwd_pkg::OFS_STATUS, 8'h00);
  endtask : t_off
  task automatic t_delay();
    doReset();
    bwd_host_model_i.doInit(16'h0003, 16'h0001, 1'h1);
    bwd_host_model_i.doTrigger(1);
    rd(bwd_pkg::OFS_STATUS, 8'h01);
    outs(4'h8);
    // a trigger in the delay must not push the arming edge out
    repeat (UNIT - 5) @(negedge clk);
    outs(4'h8);
    @(negedge clk);
    outs(4'hc);
    repeat (3 * UNIT - 2) @(negedge clk);
    outs(4'hc);
    @(negedge clk);
    outs(4'hd);
    @(negedge clk);
    outs(4'h9);
    rd(bwd_pkg::OFS_STATUS, 8'h06);
    doReset();
    bwd_host_model_i.doInit(16'hffff, 16'h8000, 1'h1);
    @(negedge clk);
    outs(4'hc);
  endtask : t_delay
  task automatic t_i2c();
    doReset();
    wr(bwd_pkg::OFS_TIMEOUT_LO, 8'h02);
    wr(bwd_pkg::OFS_TIMEOUT_HI, 8'h00);
    wr(bwd_pkg::OFS_DELAY_LO, 8'h00);
    wr(bwd_pkg::OFS_DELAY_HI, 8'h80);
    wr(bwd_pkg::OFS_ACTION, 8'h01);
    wr(bwd_pkg::OFS_COMMAND, bwd_pkg::CMD_INIT);
    repeat (2) @(negedge clk);
    outs(4'hc);
    wr(bwd_pkg::OFS_COMMAND, bwd_pkg::CMD_TRIGGER);
    outs(4'hc);
    rd(bwd_pkg::OFS_STATUS, 8'h03);
    // the i2c trigger acts one edge after its write; expiry two units later
    repeat (2 * UNIT - 3) @(negedge clk);
    outs(4'hc);
    @(negedge clk);
    outs(4'hd);
    rd(bwd_pkg::OFS_ACTION, 8'h01);
    rd(bwd_pkg::OFS_DELAY_HI, 8'h00);
  endtask : t_i2c
  initial begin
    {i2cWrStb, i2cRdStb, i2cAddr, i2cWrData} = 18'h0;
    t_armNow();
    t_off();
    t_delay();
    t_i2c();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
